// ===== common/dctc_defs.svh
// Offsets, reset values, field positions and sizes of the timing set
`ifndef DCTC_DEFS_SVH
`define DCTC_DEFS_SVH
// ==========================================
// Register byte offsets
`define DCTC_OFF_ACTW 12'h228
`define DCTC_OFF_RTR 12'h22C
`define DCTC_OFF_RTP 12'h230
`define DCTC_OFF_RTW 12'h234
`define DCTC_OFF_WR 12'h238
`define DCTC_OFF_WTW 12'h240
`define DCTC_OFF_STAT 12'h244
`define DCTC_OFF_WTR 12'h248
`define DCTC_OFF_CKSTP 12'h24C
`define DCTC_OFF_XMPD 12'h250
`define DCTC_OFF_EP 12'h254
`define DCTC_OFF_XP 12'h258
`define DCTC_OFF_ESR 12'h25C
`define DCTC_OFF_CTRL 12'h260
`define DCTC_OFF_XSR 12'h264
`define DCTC_OFF_ESRCK 12'h268
`define DCTC_OFF_CKXSR 12'h26C
`define DCTC_OFF_CMD 12'h270
// ==========================================
// Reset values
`define DCTC_RST_ACTW 32'h0000_0010
`define DCTC_RST_RTR 32'h0356_1414
`define DCTC_RST_RTP 32'h0000_0004
`define DCTC_RST_RTW 32'h1006_0404
`define DCTC_RST_WR 32'h0000_0005
`define DCTC_RST_WTW 32'h0000_0000
`define DCTC_RST_WTR 32'h0000_0005
`define DCTC_RST_CKSTP 32'h1006_0404
`define DCTC_RST_XMPD 32'h0000_0505
`define DCTC_RST_EP 32'h0000_0002
`define DCTC_RST_XP 32'h0000_0002
`define DCTC_RST_ESR 32'h0000_0002
`define DCTC_RST_XSR 32'h0512_0100
`define DCTC_RST_ESRCK 32'h0000_0005
`define DCTC_RST_CKXSR 32'h0000_0001
`define DCTC_RST_CMD 32'h0000_0000
// ==========================================
// Field positions
`define DCTC_LANE_S 0
`define DCTC_LANE_L 8
`define DCTC_LANE_CS 16
`define DCTC_LANE_DLR 24
`define DCTC_XP_DLL 8
`define DCTC_MAWN_LSB 8
`define DCTC_MAWL_LSB 16
`define DCTC_CTRL_APPLY 0
`define DCTC_CTRL_PEND 1
// ==========================================
// Sizes
`define DCTC_CNT_W 10
`define DCTC_NENT 64
`define DCTC_NREG 16
`endif

// ===== common/dctc_pkg.sv
// Types shared by the timing constraint block
`include "dctc_defs.svh"
package dctc_pkg;
    // Commands seen from the scheduler
    typedef enum logic [3:0] {
        K_NOP, K_ACT, K_RD, K_WR, K_PRE, K_PDE, K_PDX, K_PDXD,
        K_SRE, K_SRX, K_MPDE, K_MPDX, K_CKOFF, K_CKON
    } dctc_kind_e;
    // Candidate command with its target
    typedef struct packed {
        dctc_kind_e kind;
        logic chip;
        logic lrank;
        logic [1:0] bg;
        logic [1:0] bank;
    } dctc_cmd_s;
    // Register slots
    typedef enum logic [3:0] {
        R_ACTW, R_RTR, R_RTP, R_RTW, R_WR, R_WTW, R_WTR, R_CKSTP,
        R_XMPD, R_EP, R_XP, R_ESR, R_XSR, R_ESRCK, R_CKXSR, R_CMD
    } dctc_rid_e;
    // Relation of two targets
    typedef enum logic [1:0] {REL_S, REL_L, REL_CS, REL_DLR} dctc_rel_e;
    typedef logic [`DCTC_CNT_W-1:0] dctc_cnt_t;
    typedef logic [31:0] dctc_word_t;
    typedef dctc_cnt_t [`DCTC_NENT-1:0] dctc_ages_t;
    typedef dctc_word_t [`DCTC_NREG-1:0] dctc_regs_t;
    typedef dctc_cnt_t [1:0] dctc_pair_t;
    typedef dctc_cnt_t [3:0] dctc_faw_t;
    // Address decode result
    typedef struct packed {
        logic hit;
        logic ctrl;
        logic stat;
        dctc_rid_e rid;
    } dctc_dec_s;
    // Age array state
    typedef struct packed {
        dctc_ages_t age;
    } dctc_age_s;
    // Whole state of the top
    typedef struct packed {
        dctc_regs_t pend;
        dctc_regs_t act;
        logic ack;
        dctc_word_t dat;
        logic upd_pend;
        dctc_pair_t blk;
        dctc_pair_t esrck;
        dctc_pair_t ckxsr;
        dctc_faw_t [1:0] faw;
        logic [1:0][15:0] maw_t;
        logic [1:0][7:0] maw_n;
    } dctc_st_s;
endpackage : dctc_pkg

// ===== core/dctc_age_array.sv
// Saturating per-bank age counters since the last marked command
`timescale 1ns/1ps
module dctc_age_array (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic [5:0] clr_idx,
    output dctc_pkg::dctc_ages_t ages
);
    import dctc_pkg::*;

    dctc_age_s st_ff; // Registered ages
    dctc_age_s nxt_st; // Next ages

    // ==========================================
    // Ageing
    // Every entry counts up and sticks at all ones
    always_comb begin
        nxt_st = st_ff;
        for (int i = 0; i < `DCTC_NENT; i++) begin
            if (st_ff.age[i] != '1) begin
                nxt_st.age[i] = st_ff.age[i] + 1'b1;
            end
        end
        // New command restarts its bank; its issue edge is cycle one
        if (clr) begin
            nxt_st.age[clr_idx] = 10'h001;
        end
    end

    // All ones at reset means no history
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ages = st_ff.age;

    a_age_restart: assert property (@(posedge clk) disable iff (rst) // R21
        clr |=> ages[$past(clr_idx)] == 10'h001)
        else $error("age not restarted by command");
endmodule : dctc_age_array

// ===== core/dctc_timing.sv
// Command spacing constraint set of the memory controller
// Contract
// R1: Activates obey four-activate and maximum windows
// R2: Read to read spacing by four relations
// R3: Read to write spacing by three relations
// R4: Read to precharge wait per bank
// R5: Write recovery blocks non-writes same bank
// R6: Software sets recovery from latency plus four
// R7: Write to read spacing from write start
// R8: Write to write spacing by four relations
// R9: Software pads write spacing for checksum
// R10: Clock stop blocks rank for count
// R11: Deep power-down exit blocks rank for count
// R12: Power-down entry blocks rank for count
// R13: Separate no-DLL and DLL exit delays
// R14: Software bounds both exit delays
// R15: Self-refresh entry blocks rank for count
// R16: Self-refresh exit blocks rank for count
// R17: Wait after entry before clock off
// R18: Wait after clock on before exit
// R19: Thirty-two bit command signalling timing register
// R20: All registers readable and writable always; the status register ignores writes
// R21: Counts in clock cycles per target
// R22: Values take effect on applied update
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "dctc_defs.svh"
module dctc_timing (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [11:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output dctc_pkg::dctc_word_t WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic CMD_VALID,
    input dctc_pkg::dctc_cmd_s CMD,
    output logic CMD_READY,
    input wire logic CTRL_IDLE,
    output dctc_pkg::dctc_word_t CMD_TIMING
);
    import dctc_pkg::*;

    // ==========================================
    // Declarations
    dctc_st_s st_ff; // Registered state
    dctc_st_s nxt_st; // Next state
    dctc_ages_t rd_age; // Cycles since last read per bank
    dctc_ages_t wr_age; // Cycles since last write per bank
    logic fire; // Command issued this cycle
    logic [5:0] me; // Bank index of the candidate
    logic req; // New bus request
    dctc_dec_s dec; // Decoded bus address

    // ==========================================
    // Functions
    // Register slot, status or control from a byte address
    function automatic dctc_dec_s decode(input logic [11:0] a);
        dctc_dec_s d;
        d = '{hit: 1'b1, ctrl: 1'b0, stat: 1'b0, rid: R_ACTW};
        unique case ({a[11:2], 2'b00})
            `DCTC_OFF_ACTW: d.rid = R_ACTW;
            `DCTC_OFF_RTR: d.rid = R_RTR;
            `DCTC_OFF_RTP: d.rid = R_RTP;
            `DCTC_OFF_RTW: d.rid = R_RTW;
            `DCTC_OFF_WR: d.rid = R_WR;
            `DCTC_OFF_WTW: d.rid = R_WTW;
            `DCTC_OFF_WTR: d.rid = R_WTR;
            `DCTC_OFF_CKSTP: d.rid = R_CKSTP;
            `DCTC_OFF_XMPD: d.rid = R_XMPD;
            `DCTC_OFF_EP: d.rid = R_EP;
            `DCTC_OFF_XP: d.rid = R_XP;
            `DCTC_OFF_ESR: d.rid = R_ESR;
            `DCTC_OFF_XSR: d.rid = R_XSR;
            `DCTC_OFF_ESRCK: d.rid = R_ESRCK;
            `DCTC_OFF_CKXSR: d.rid = R_CKXSR;
            `DCTC_OFF_CMD: d.rid = R_CMD;
            // Side registers
            `DCTC_OFF_CTRL: begin
                d.hit = 1'b0;
                d.ctrl = 1'b1;
            end
            `DCTC_OFF_STAT: begin
                d.hit = 1'b0;
                d.stat = 1'b1;
            end
            // Unmapped reads zero
            default: d.hit = 1'b0;
        endcase
        return d;
    endfunction : decode

    // Reset value of one register slot
    function automatic dctc_word_t reset_of(input dctc_rid_e r);
        dctc_word_t v;
        unique case (r)
            R_ACTW: v = `DCTC_RST_ACTW;
            R_RTR: v = `DCTC_RST_RTR;
            R_RTP: v = `DCTC_RST_RTP;
            R_RTW: v = `DCTC_RST_RTW;
            R_WR: v = `DCTC_RST_WR;
            R_WTW: v = `DCTC_RST_WTW;
            R_WTR: v = `DCTC_RST_WTR;
            R_CKSTP: v = `DCTC_RST_CKSTP;
            R_XMPD: v = `DCTC_RST_XMPD;
            R_EP: v = `DCTC_RST_EP;
            R_XP: v = `DCTC_RST_XP;
            R_ESR: v = `DCTC_RST_ESR;
            R_XSR: v = `DCTC_RST_XSR;
            R_ESRCK: v = `DCTC_RST_ESRCK;
            R_CKXSR: v = `DCTC_RST_CKXSR;
            R_CMD: v = `DCTC_RST_CMD;
        endcase
        return v;
    endfunction : reset_of

    // Low count field of a register
    function automatic dctc_cnt_t fld(input dctc_word_t w);
        return w[`DCTC_CNT_W-1:0];
    endfunction : fld

    // Byte lane chosen by the relation of two targets
    function automatic dctc_cnt_t lane(input dctc_word_t w, input dctc_rel_e r);
        logic [7:0] b;
        unique case (r)
            REL_S: b = w[`DCTC_LANE_S +: 8];
            REL_L: b = w[`DCTC_LANE_L +: 8];
            REL_CS: b = w[`DCTC_LANE_CS +: 8];
            REL_DLR: b = w[`DCTC_LANE_DLR +: 8];
        endcase
        return {2'b00, b};
    endfunction : lane

    // Relation of bank entry i to the candidate
    function automatic dctc_rel_e rel_of(input int i, input dctc_cmd_s c);
        logic [5:0] ix;
        ix = 6'(i);
        if (ix[5] != c.chip) begin
            return REL_CS;
        end else if (ix[4] != c.lrank) begin
            return REL_DLR;
        end else if (ix[3:2] == c.bg) begin
            return REL_L;
        end
        return REL_S;
    endfunction : rel_of

    // Decrement then raise to a new wait
    function automatic dctc_cnt_t ld(input dctc_cnt_t cur, input dctc_cnt_t val);
        dctc_cnt_t dec;
        dec = cur - {9'b0, (cur != '0)};
        return (val > dec) ? val : dec;
    endfunction : ld

    // Whether the candidate may issue now
    function automatic logic may_issue(input dctc_st_s s, input dctc_ages_t ar,
                                       input dctc_ages_t aw, input dctc_cmd_s c);
        logic ok;
        logic bank_cmd;
        logic [5:0] m;
        dctc_rel_e r;
        dctc_rel_e r3;
        ok = 1'b1;
        m = {c.chip, c.lrank, c.bg, c.bank};
        bank_cmd = (c.kind == K_ACT) || (c.kind == K_RD) || (c.kind == K_PRE);
        // Rank wait from clock stop, power-down and self-refresh
        if (s.blk[c.chip] > 10'h001) begin
            ok = 1'b0; // R10 R11 R12 R13 R15 R16
        end
        for (int i = 0; i < `DCTC_NENT; i++) begin
            r = rel_of(i, c);
            // Three-lane registers treat other logical rank as other chip
            r3 = (r == REL_DLR) ? REL_CS : r;
            // Read after read or write
            if (c.kind == K_RD && ar[i] < lane(s.act[R_RTR], r)) begin
                ok = 1'b0; // R2
            end
            if (c.kind == K_RD && aw[i] < lane(s.act[R_WTR], r3)) begin
                ok = 1'b0; // R7
            end
            // Write after read or write
            if (c.kind == K_WR && ar[i] < lane(s.act[R_RTW], r3)) begin
                ok = 1'b0; // R3
            end
            if (c.kind == K_WR && aw[i] < lane(s.act[R_WTW], r)) begin
                ok = 1'b0; // R8
            end
            // Recovery: the bank itself, or every bank for rank commands
            if (c.kind != K_WR && c.kind != K_NOP && r != REL_CS
                && (!bank_cmd || 6'(i) == m) && aw[i] < fld(s.act[R_WR])) begin
                ok = 1'b0; // R5
            end
        end
        unique case (c.kind)
            // Read to precharge same bank
            K_PRE: begin
                if (ar[m] < fld(s.act[R_RTP])) begin
                    ok = 1'b0; // R4
                end
            end
            // Four-activate and maximum windows
            K_ACT: begin
                if (s.faw[c.chip][3] < {2'b00, s.act[R_ACTW][7:0]}) begin
                    ok = 1'b0; // R1
                end
                if (s.act[R_ACTW][`DCTC_MAWN_LSB +: 8] != 8'h00
                    && s.maw_n[c.chip] >= s.act[R_ACTW][`DCTC_MAWN_LSB +: 8]) begin
                    ok = 1'b0; // R1
                end
            end
            // Clock off only after the entry wait
            K_CKOFF: begin
                if (s.esrck[c.chip] > 10'h001) begin
                    ok = 1'b0; // R17
                end
            end
            // Self-refresh and deep power-down exits only after the clock-on wait
            K_SRX, K_MPDX: begin
                if (s.ckxsr[c.chip] > 10'h001) begin
                    ok = 1'b0; // R18
                end
            end
            K_NOP: ok = 1'b1;
            default: ;
        endcase
        return ok;
    endfunction : may_issue

    // ==========================================
    // Bank age trackers
    assign me = {CMD.chip, CMD.lrank, CMD.bg, CMD.bank};
    assign fire = CMD_VALID && CMD_READY;

    // Ages since the last read per bank
    dctc_age_array u_rd_age (
        .clk(CLK_SYS),
        .rst(RST),
        .clr(fire && CMD.kind == K_RD),
        .clr_idx(me),
        .ages(rd_age)
    );

    // Ages since the start of the last write per bank
    dctc_age_array u_wr_age (
        .clk(CLK_SYS),
        .rst(RST),
        .clr(fire && CMD.kind == K_WR),
        .clr_idx(me),
        .ages(wr_age)
    );

    // Readiness against the applied values only
    assign CMD_READY = may_issue(st_ff, rd_age, wr_age, CMD); // R21 R22

    // ==========================================
    // Next state
    assign req = WB_CYC_I && WB_STB_I && !st_ff.ack;
    assign dec = decode(WB_ADR_I);

    // Bus slave, update, rank waits and activate windows
    always_comb begin
        nxt_st = st_ff;
        // Counters run one step per clock
        for (int c = 0; c < 2; c++) begin
            nxt_st.blk[c] = ld(st_ff.blk[c], '0); // R21
            nxt_st.esrck[c] = ld(st_ff.esrck[c], '0);
            nxt_st.ckxsr[c] = ld(st_ff.ckxsr[c], '0);
            for (int k = 0; k < 4; k++) begin
                if (st_ff.faw[c][k] != '1) begin
                    nxt_st.faw[c][k] = st_ff.faw[c][k] + 1'b1;
                end
            end
            // Maximum window restarts when its length runs out
            if (st_ff.maw_t[c] == 16'h0000) begin
                nxt_st.maw_t[c] = st_ff.act[R_ACTW][`DCTC_MAWL_LSB +: 16];
                nxt_st.maw_n[c] = 8'h00;
            end else begin
                nxt_st.maw_t[c] = st_ff.maw_t[c] - 16'h0001;
            end
        end
        // Issued command arms its waits
        if (fire) begin
            unique case (CMD.kind)
                K_ACT: begin
                    nxt_st.faw[CMD.chip] = {nxt_st.faw[CMD.chip][2:0], 10'h001}; // R1
                    if (nxt_st.maw_n[CMD.chip] != 8'hFF) begin
                        nxt_st.maw_n[CMD.chip] = nxt_st.maw_n[CMD.chip] + 8'h01;
                    end
                end
                K_PDE: nxt_st.blk[CMD.chip] =
                    ld(st_ff.blk[CMD.chip], fld(st_ff.act[R_EP])); // R12
                K_PDX: nxt_st.blk[CMD.chip] =
                    ld(st_ff.blk[CMD.chip], {2'b00, st_ff.act[R_XP][7:0]}); // R13
                K_PDXD: nxt_st.blk[CMD.chip] = ld(st_ff.blk[CMD.chip],
                    {2'b00, st_ff.act[R_XP][`DCTC_XP_DLL +: 8]}); // R13
                K_SRE: begin
                    nxt_st.blk[CMD.chip] =
                        ld(st_ff.blk[CMD.chip], fld(st_ff.act[R_ESR])); // R15
                    nxt_st.esrck[CMD.chip] =
                        ld(st_ff.esrck[CMD.chip], fld(st_ff.act[R_ESRCK])); // R17
                end
                K_SRX: nxt_st.blk[CMD.chip] =
                    ld(st_ff.blk[CMD.chip], fld(st_ff.act[R_XSR])); // R16
                K_MPDE: nxt_st.esrck[CMD.chip] =
                    ld(st_ff.esrck[CMD.chip], fld(st_ff.act[R_ESRCK])); // R17
                K_MPDX: nxt_st.blk[CMD.chip] =
                    ld(st_ff.blk[CMD.chip], fld(st_ff.act[R_XMPD])); // R11
                K_CKOFF: nxt_st.blk[CMD.chip] =
                    ld(st_ff.blk[CMD.chip], fld(st_ff.act[R_CKSTP])); // R10
                K_CKON: nxt_st.ckxsr[CMD.chip] =
                    ld(st_ff.ckxsr[CMD.chip], fld(st_ff.act[R_CKXSR])); // R18
                default: ;
            endcase
        end
        // Pending values go live only while the scheduler is idle
        if (st_ff.upd_pend && CTRL_IDLE) begin
            nxt_st.act = st_ff.pend; // R22
            nxt_st.upd_pend = 1'b0;
        end
        // Bus answer one cycle after the request
        nxt_st.ack = req;
        if (req) begin
            nxt_st.dat = '0;
            if (dec.hit) begin
                nxt_st.dat = st_ff.pend[dec.rid]; // R20
            end else if (dec.ctrl) begin
                nxt_st.dat[`DCTC_CTRL_PEND] = st_ff.upd_pend;
            end else if (dec.stat) begin
                nxt_st.dat[1:0] = {st_ff.blk[1] > 10'h001, st_ff.blk[0] > 10'h001};
                nxt_st.dat[3:2] = {st_ff.ckxsr[1] > 10'h001, st_ff.ckxsr[0] > 10'h001};
                nxt_st.dat[5:4] = {st_ff.esrck[1] > 10'h001, st_ff.esrck[0] > 10'h001};
            end
            // Byte-lane write into the pending copy
            if (WB_WE_I && dec.hit) begin
                for (int b = 0; b < 4; b++) begin
                    if (WB_SEL_I[b]) begin
                        nxt_st.pend[dec.rid][b*8 +: 8] = WB_DAT_I[b*8 +: 8]; // R20
                    end
                end
            end
            // Update request wins over a same-cycle apply
            if (WB_WE_I && dec.ctrl && WB_SEL_I[0] && WB_DAT_I[`DCTC_CTRL_APPLY]) begin
                nxt_st.upd_pend = 1'b1; // R22
            end
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_ff <= '0;
            for (int r = 0; r < `DCTC_NREG; r++) begin
                st_ff.pend[r] <= reset_of(dctc_rid_e'(r));
                st_ff.act[r] <= reset_of(dctc_rid_e'(r));
            end
            st_ff.faw <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops
    assign WB_ACK_O = st_ff.ack;
    assign WB_DAT_O = st_ff.dat;
    assign CMD_TIMING = st_ff.act[R_CMD]; // R19

    // ==========================================
    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // Self-refresh entry with a real wait
    sequence s_sre_long;
        fire && CMD.kind == K_SRE && fld(st_ff.act[R_ESR]) > 10'h002;
    endsequence

    // Clock off with a real wait
    sequence s_ckoff_long;
        fire && CMD.kind == K_CKOFF && fld(st_ff.act[R_CKSTP]) > 10'h002;
    endsequence

    a_bus_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O) // R20
        else $error("ack held over two cycles");
    a_bus_ack_next: assert property (req |=> WB_ACK_O) // R20
        else $error("request not answered next cycle");
    a_upd_copy: assert property ((st_ff.upd_pend && CTRL_IDLE) // R22
        |=> st_ff.act == $past(st_ff.pend))
        else $error("update did not copy pending values");
    a_upd_hold: assert property (!(st_ff.upd_pend && CTRL_IDLE) // R22
        |=> $stable(st_ff.act))
        else $error("live values changed without update");
    a_sre_block: assert property (s_sre_long // R15
        |=> !(fire && CMD.chip == $past(CMD.chip)) [*2])
        else $error("command inside self-refresh entry wait");
    a_ckoff_load: assert property (s_ckoff_long // R10
        |=> st_ff.blk[$past(CMD.chip)] >= $past(fld(st_ff.act[R_CKSTP])))
        else $error("clock stop wait not armed");
    a_pre_recover: assert property ((fire && CMD.kind == K_PRE) // R5
        |-> wr_age[me] >= fld(st_ff.act[R_WR]) && rd_age[me] >= fld(st_ff.act[R_RTP]))
        else $error("precharge inside recovery");
    a_faw_window: assert property ((fire && CMD.kind == K_ACT) // R1
        |-> st_ff.faw[CMD.chip][3] >= {2'b00, st_ff.act[R_ACTW][7:0]})
        else $error("fifth activate inside window");
    a_clk_off_wait: assert property ((fire && CMD.kind == K_CKOFF) // R17
        |-> st_ff.esrck[CMD.chip] <= 10'h001)
        else $error("clock stopped too soon after entry");
    a_exit_wait: assert property ((fire && CMD.kind == K_SRX) // R18
        |-> st_ff.ckxsr[CMD.chip] <= 10'h001)
        else $error("exit too soon after clock on");
endmodule : dctc_timing

// ===== dv/dctc_sched_model.sv
// Scheduler stand-in that offers commands to the spacing block
`timescale 1ns/1ps
module dctc_sched_model
    import dctc_pkg::*;
(
    input wire logic clk,
    input wire logic ready,
    output logic valid,
    output dctc_cmd_s cmd
);
    initial valid = 1'h0;
    initial cmd = '0;
    // Hold a command until the edge that takes it; count edges waited
    task automatic offer(input dctc_cmd_s c, output int n);
        valid <= 1'h1;
        cmd <= c;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ready !== 1'h1 && n < 999);
        @(posedge clk);
    endtask : offer
    // Withdraw after the taking edge
    task automatic idle();
        valid <= 1'h0;
    endtask : idle
endmodule : dctc_sched_model

// ===== dv/testbench.sv
// Self-checking bench of the command spacing block
`timescale 1ns/1ps
`include "dctc_defs.svh"
module testbench;
    import dctc_pkg::*;
    logic clk, rst, cyc, stb, we, idl, ack, vld, rdy;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] wd;
    dctc_word_t rd, tmg;
    dctc_cmd_s cmd;
    int fails = 0;
    int compares = 0;
    int cyc_n = 0;
    dctc_timing DUT (.CLK_SYS(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd),
        .WB_ACK_O(ack), .CMD_VALID(vld), .CMD(cmd), .CMD_READY(rdy), .CTRL_IDLE(idl),
        .CMD_TIMING(tmg));
    dctc_sched_model SCHED (.clk(clk), .ready(rdy), .valid(vld), .cmd(cmd));
    // ==========================================
    // Clock and hang guard
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 30000) begin
            fails++;
            print_verdict();
        end
    end
    // Compare one word
    task automatic chk(input string nm, input logic [31:0] e, s);
        compares++;
        if (e !== s) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Pulse reset for twelve cycles
    task automatic rst_seq();
        rst <= 1'h1;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
    endtask : rst_seq
    // One classic Wishbone cycle
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output dctc_word_t q);
        {cyc, stb, we, adr, wd, sel} <= {2'h3, w, a, d, 4'hF};
        do begin
            @(posedge clk);
        end while (ack !== 1'h1);
        q = rd;
        {cyc, stb, we} <= 3'h0;
        @(posedge clk);
    endtask : wb
    // Build a command
    function automatic dctc_cmd_s c(dctc_kind_e k, logic h, l, logic [1:0] b, n);
        return '{k, h, l, b, n};
    endfunction : c
    // Two commands from reset; edges from first issue to second
    task automatic gap(input dctc_cmd_s a, b, input int e);
        int n;
        rst_seq();
        SCHED.offer(a, n);
        SCHED.offer(b, n);
        SCHED.idle();
        chk("gap", 32'(e), 32'(n));
    endtask : gap
    // Reset values and an unmapped place
    task automatic resets();
        logic [11:0] o [12] = '{`DCTC_OFF_RTR, `DCTC_OFF_RTW, `DCTC_OFF_WR, `DCTC_OFF_WTR,
            `DCTC_OFF_CKSTP, `DCTC_OFF_XMPD, `DCTC_OFF_XP, `DCTC_OFF_ESR, `DCTC_OFF_XSR,
            `DCTC_OFF_ESRCK, `DCTC_OFF_CKXSR, 12'h2FC};
        logic [31:0] v [12] = '{32'h0356_1414, 32'h1006_0404, 32'h0000_0005, 32'h0000_0005,
            32'h1006_0404, 32'h0000_0505, 32'h0000_0002, 32'h0000_0002, 32'h0512_0100,
            32'h0000_0005, 32'h0000_0001, 32'h0000_0000};
        dctc_word_t q;
        rst_seq();
        wb(1'h1, 12'h2FC, 32'hFFFF_FFFF, q);
        foreach (o[i]) begin
            wb(1'h0, o[i], 32'h0, q);
            chk("reset value", v[i], q);
        end
    endtask : resets
    // Five activates: the fifth waits for the window
    task automatic faw();
        int n;
        int t = 0;
        rst_seq();
        for (int i = 0; i < 5; i++) begin
            SCHED.offer(c(K_ACT, 0, 0, 2'(i), 2'(i / 4)), n);
            t += n;
        end
        SCHED.idle();
        chk("act window", 32'(17), 32'(t));
    endtask : faw
    // New values wait for an idle controller
    task automatic pend();
        dctc_word_t q;
        int n;
        rst_seq();
        idl <= 1'h0;
        wb(1'h1, `DCTC_OFF_RTR, 32'h0356_0314, q);
        wb(1'h1, `DCTC_OFF_CMD, 32'hA5A5_5A5A, q);
        wb(1'h1, `DCTC_OFF_ESR, 32'h0000_0005, q);
        wb(1'h1, `DCTC_OFF_CTRL, 32'h0000_0001, q);
        wb(1'h0, `DCTC_OFF_RTR, 32'h0, q);
        chk("readback", 32'h0356_0314, q);
        wb(1'h0, `DCTC_OFF_CTRL, 32'h0, q);
        chk("pending", 32'h0000_0002, q);
        chk("timing held", 32'h0, tmg);
        SCHED.offer(c(K_RD, 0, 0, 0, 0), n);
        SCHED.offer(c(K_RD, 0, 0, 0, 1), n);
        SCHED.idle();
        chk("gap", 32'(20), 32'(n));
        idl <= 1'h1;
        repeat (30) @(posedge clk);
        chk("timing", 32'hA5A5_5A5A, tmg);
        SCHED.offer(c(K_RD, 0, 0, 0, 0), n);
        SCHED.offer(c(K_RD, 0, 0, 0, 1), n);
        SCHED.idle();
        chk("gap", 32'(3), 32'(n));
        SCHED.offer(c(K_SRE, 0, 0, 0, 0), n);
        SCHED.offer(c(K_RD, 0, 0, 0, 0), n);
        SCHED.idle();
        chk("gap", 32'(5), 32'(n));
    endtask : pend
    // ==========================================
    // Main sequence
    initial begin
        {cyc, stb, we, adr, wd, sel} = '0;
        rst = 1'h1;
        idl = 1'h1;
        @(posedge clk);
        resets();
        gap(c(K_RD, 0, 0, 0, 0), c(K_RD, 0, 0, 0, 1), 20);
        gap(c(K_RD, 0, 0, 0, 0), c(K_RD, 1, 0, 0, 0), 86);
        gap(c(K_RD, 0, 0, 0, 0), c(K_RD, 0, 1, 0, 0), 3);
        gap(c(K_RD, 0, 0, 0, 0), c(K_WR, 0, 0, 1, 0), 4);
        gap(c(K_RD, 0, 0, 0, 0), c(K_PRE, 0, 0, 0, 0), 4);
        gap(c(K_WR, 0, 0, 0, 0), c(K_PRE, 0, 0, 0, 0), 5);
        gap(c(K_WR, 0, 0, 0, 0), c(K_RD, 0, 0, 1, 0), 5);
        gap(c(K_WR, 0, 0, 0, 0), c(K_WR, 0, 0, 1, 0), 1);
        gap(c(K_CKOFF, 0, 0, 0, 0), c(K_RD, 0, 0, 0, 0), 4);
        gap(c(K_MPDX, 0, 0, 0, 0), c(K_RD, 0, 0, 0, 0), 261);
        gap(c(K_PDE, 0, 0, 0, 0), c(K_PDX, 0, 0, 0, 0), 2);
        gap(c(K_PDX, 0, 0, 0, 0), c(K_RD, 0, 0, 0, 0), 2);
        gap(c(K_PDXD, 0, 0, 0, 0), c(K_RD, 0, 0, 0, 0), 1);
        gap(c(K_SRE, 0, 0, 0, 0), c(K_ACT, 0, 0, 0, 0), 2);
        gap(c(K_SRX, 0, 0, 0, 0), c(K_RD, 0, 0, 0, 0), 256);
        gap(c(K_SRE, 0, 0, 0, 0), c(K_CKOFF, 0, 0, 0, 0), 5);
        gap(c(K_CKON, 0, 0, 0, 0), c(K_SRX, 0, 0, 0, 0), 1);
        faw();
        pend();
        print_verdict();
    end
    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
endmodule : testbench
